// ===== ioxp_i2c_slave.sv
// Purpose: Two-wire serial slave with eight monitored I/O ports and a latched change interrupt.
// Assumes: All pins except reset_n are asynchronous to mclk and pass two flip-flops before use.
// Notes:   mclk must run far faster than the serial clock; edges are found by sampling.
`timescale 1ns/1ps
`default_nettype none

module ioxp_i2c_slave
   import ioxp_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       bus_abort_n,
   input  wire logic       pin_addr_bit,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic [3:0] open_drain_ports_i,
   output logic      [3:0] open_drain_ports_o,
   output logic      [3:0] open_drain_ports_oe,
   input  wire logic [3:0] push_pull_ports_i,
   output logic      [3:0] push_pull_ports_o,
   output logic      [3:0] push_pull_ports_oe,
   output logic            change_irq_n_o,
   output logic            change_irq_n_oe
);

   // Register read selection, used by the first and every repeated read byte.
   function automatic logic [7:0] reg_read(input logic [7:0] cmd, input logic [7:0] snap,
                                           input ioxp_grp_t a, input ioxp_grp_t b);
      logic [3:0] v;
      v = 4'h0;
      case (cmd)
         IOXP_CMD_IN_A:   v = snap[3:0];
         IOXP_CMD_IN_B:   v = snap[7:4];
         IOXP_CMD_OUT_A:  v = a.out;
         IOXP_CMD_OUT_B:  v = b.out;
         IOXP_CMD_DIR_A:  v = a.dir;
         IOXP_CMD_DIR_B:  v = b.dir;
         IOXP_CMD_MASK_A: v = a.mask;
         IOXP_CMD_MASK_B: v = b.mask;
         default:         v = 4'h0;
      endcase
      return {v, 4'h0};
   endfunction

   logic [3:0]  meta_q;
   logic [3:0]  sync_q;
   logic [7:0]  pin_m_q;
   logic [7:0]  pin_q;
   logic        scl_p_q;
   logic        sda_p_q;
   ioxp_state_t st_q, st_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [7:0]  sh_q, sh_d;
   logic [1:0]  byte_q, byte_d;
   logic        rd_q, rd_d;
   logic [7:0]  cmd_q, cmd_d;
   logic        oe_q, oe_d;
   logic [7:0]  snap_q;
   logic [7:0]  ref_q;
   logic [1:0]  flag_q;
   ioxp_grp_t   grp_a_q;
   ioxp_grp_t   grp_b_q;

   // Two-stage synchronisers; the first stage feeds only the second.
   always_ff @(posedge mclk) begin
      meta_q  <= {pin_addr_bit, bus_abort_n, sda_i, scl_i};
      sync_q  <= meta_q;
      pin_m_q <= {push_pull_ports_i, open_drain_ports_i};
      pin_q   <= pin_m_q;
      scl_p_q <= sync_q[0];
      sda_p_q <= sync_q[1];
   end

   wire scl_s   = sync_q[0];
   wire sda_s   = sync_q[1];
   wire abort_n = sync_q[2];
   wire ad_s    = sync_q[3];
   wire ser_rst = !reset_n || !abort_n;

   // Line events found from sampled levels.
   wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire scl_rise  = scl_s & ~scl_p_q;
   wire scl_fall  = ~scl_s & scl_p_q;
   wire line_evt  = start_det | stop_det;
   wire byte_end  = (st_q == IOXP_ST_RX) && scl_fall && (cnt_q == IOXP_BIT_LAST) && !line_evt;
   wire addr_hit  = (sh_q[7:3] == IOXP_FIXED_ADDR) && (sh_q[2] == ad_s) && !sh_q[1];
   wire is_addr   = byte_q == IOXP_BYTE_ADDR;
   wire snap_go   = byte_end && is_addr && addr_hit && sh_q[0] && abort_n;
   wire wr_go     = byte_end && (byte_q == IOXP_BYTE_DATA) && abort_n;
   wire [7:0] rd_data = reg_read(cmd_q, snap_q, grp_a_q, grp_b_q);

   // Only a read of a port register clears that group; the cmd low bit names the group.
   wire port_rd = (cmd_q <= IOXP_CMD_OUT_B);
   wire clr_a   = snap_go && port_rd && !cmd_q[0];
   wire clr_b   = snap_go && port_rd && cmd_q[0];

   // Changes only count on enabled inputs, so writing output levels can never flag.
   wire [7:0] watch = {grp_b_q.dir & ~grp_b_q.mask, grp_a_q.dir & ~grp_a_q.mask};
   wire [7:0] chg   = (pin_q ^ ref_q) & watch;
   wire set_a = |chg[3:0];
   wire set_b = |chg[7:4];

   // Serial sequencer; start and stop override every state.
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      byte_d = byte_q;
      rd_d = rd_q;
      cmd_d = cmd_q;
      oe_d = oe_q;
      if (start_det) begin
         st_d = IOXP_ST_RX;
         cnt_d = 4'h0;
         byte_d = IOXP_BYTE_ADDR;
         oe_d = 1'b0;
      end else if (stop_det) begin
         st_d = IOXP_ST_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            IOXP_ST_RX: begin
               if (scl_rise && cnt_q != IOXP_BIT_LAST) begin
                  sh_d = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end else if (byte_end) begin
                  if (is_addr && !addr_hit) begin
                     st_d = IOXP_ST_IGNORE;
                  end else begin
                     st_d = IOXP_ST_RX_ACK;
                     oe_d = 1'b1;
                  end
                  if (is_addr) begin
                     rd_d = sh_q[0];
                  end
                  if (byte_q == IOXP_BYTE_CMD) begin
                     cmd_d = sh_q;
                  end
                  if (byte_q != IOXP_BYTE_DATA) begin
                     byte_d = byte_q + 2'h1;
                  end
               end
            end
            IOXP_ST_RX_ACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (rd_q) begin
                     st_d = IOXP_ST_TX;
                     sh_d = rd_data;
                     oe_d = ~rd_data[7];
                  end else begin
                     st_d = IOXP_ST_RX;
                     oe_d = 1'b0;
                  end
               end
            end
            IOXP_ST_TX: begin
               if (scl_fall) begin
                  if (cnt_q == 4'h7) begin
                     st_d = IOXP_ST_TX_ACK;
                     oe_d = 1'b0;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     cnt_d = cnt_q + 4'h1;
                     oe_d = ~sh_q[6];
                  end
               end
            end
            IOXP_ST_TX_ACK: begin
               // A master nack ends our part; the bus stays released until stop.
               if (scl_rise) begin
                  if (sda_s) begin
                     st_d = IOXP_ST_IGNORE;
                  end else begin
                     cnt_d = IOXP_BIT_LAST;
                  end
               end else if (scl_fall && cnt_q == IOXP_BIT_LAST) begin
                  st_d = IOXP_ST_TX;
                  cnt_d = 4'h0;
                  sh_d = rd_data;
                  oe_d = ~rd_data[7];
               end
            end
            IOXP_ST_IDLE, IOXP_ST_IGNORE: begin
               oe_d = 1'b0;
            end
            default: begin
               st_d = IOXP_ST_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   // Abort resets only the serial side, leaving flags and interrupt untouched.
   always_ff @(posedge mclk) begin
      if (ser_rst) begin
         st_q   <= IOXP_ST_IDLE;
         cnt_q  <= 4'h0;
         sh_q   <= 8'h00;
         byte_q <= IOXP_BYTE_ADDR;
         rd_q   <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         sh_q   <= sh_d;
         byte_q <= byte_d;
         rd_q   <= rd_d;
         oe_q   <= oe_d;
      end
   end

   // Command survives abort so a later read still targets the last register chosen.
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cmd_q <= IOXP_CMD_RESET;
      end else if (abort_n) begin
         cmd_q <= cmd_d;
      end
   end

   // Snapshot, reference and flags; the clear wins because the reference moves to the pins.
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         snap_q <= pin_q;
         ref_q  <= pin_q;
         flag_q <= 2'b00;
      end else begin
         if (snap_go) begin
            snap_q <= pin_q;
         end
         if (clr_a) begin
            ref_q[3:0] <= pin_q[3:0];
         end
         if (clr_b) begin
            ref_q[7:4] <= pin_q[7:4];
         end
         flag_q[0] <= clr_a ? 1'b0 : (flag_q[0] | set_a);
         flag_q[1] <= clr_b ? 1'b0 : (flag_q[1] | set_b);
      end
   end

   // Output levels power up from the strap; the master should send a zero low nibble.
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         grp_a_q <= '{out: {4{ad_s}}, dir: IOXP_DIR_RESET, mask: IOXP_MASK_RESET};
         grp_b_q <= '{out: {4{ad_s}}, dir: IOXP_DIR_RESET, mask: IOXP_MASK_RESET};
      end else if (wr_go) begin
         case (cmd_q)
            IOXP_CMD_OUT_A:  grp_a_q.out  <= sh_q[7:4];
            IOXP_CMD_OUT_B:  grp_b_q.out  <= sh_q[7:4];
            IOXP_CMD_DIR_A:  grp_a_q.dir  <= sh_q[7:4];
            IOXP_CMD_DIR_B:  grp_b_q.dir  <= sh_q[7:4];
            IOXP_CMD_MASK_A: grp_a_q.mask <= sh_q[7:4];
            IOXP_CMD_MASK_B: grp_b_q.mask <= sh_q[7:4];
            default: begin
            end
         endcase
      end
   end

   // Pin drive: open-drain pulls low only for an output at zero.
   assign sda_o               = 1'b0;
   assign sda_oe              = oe_q;
   assign open_drain_ports_o  = 4'h0;
   assign open_drain_ports_oe = ~grp_a_q.dir & ~grp_a_q.out;
   assign push_pull_ports_o   = grp_b_q.out;
   assign push_pull_ports_oe  = ~grp_b_q.dir;
   assign change_irq_n_o      = 1'b0;
   assign change_irq_n_oe     = |flag_q;

   property p_idle_free;
      @(posedge mclk) disable iff (ser_rst) (st_q == IOXP_ST_IDLE) |-> !sda_oe;
   endproperty
   a_idle_free: assert property (p_idle_free) else $error("Data line driven while idle.");

   property p_start;
      @(posedge mclk) disable iff (ser_rst) start_det |=> (st_q == IOXP_ST_RX) && (cnt_q == 4'h0) && !sda_oe;
   endproperty
   a_start: assert property (p_start) else $error("Start did not begin address reception.");

   property p_stop;
      @(posedge mclk) disable iff (ser_rst) stop_det |=> (st_q == IOXP_ST_IDLE) ##1 !sda_oe;
   endproperty
   a_stop: assert property (p_stop) else $error("Stop did not free the bus.");

   property p_miss;
      @(posedge mclk) disable iff (ser_rst) (byte_end && is_addr && !addr_hit) |=> (st_q == IOXP_ST_IGNORE) && !sda_oe;
   endproperty
   a_miss: assert property (p_miss) else $error("Foreign address was acknowledged.");

   property p_ack_low;
      @(posedge mclk) disable iff (ser_rst) (byte_end && (!is_addr || addr_hit)) |=> sda_oe [*2];
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("Received byte not acknowledged.");

   property p_out_write;
      @(posedge mclk) disable iff (!reset_n) (wr_go && cmd_q == IOXP_CMD_OUT_B) |=> push_pull_ports_o == $past(sh_q[7:4]);
   endproperty
   a_out_write: assert property (p_out_write) else $error("Output byte not applied to pins.");

   property p_change;
      @(posedge mclk) disable iff (!reset_n) (set_a && !clr_a) |=> flag_q[0] && change_irq_n_oe;
   endproperty
   a_change: assert property (p_change) else $error("Enabled input change not latched.");

   property p_release;
      @(posedge mclk) disable iff (!reset_n) clr_b |=> !flag_q[1] && (ref_q[7:4] == $past(pin_q[7:4]));
   endproperty
   a_release: assert property (p_release) else $error("Read did not clear group flag.");

   property p_abort;
      @(posedge mclk) disable iff (!reset_n) (!abort_n && !stop_det) |=> (st_q == IOXP_ST_IDLE) && (flag_q == $past(flag_q) || |chg);
   endproperty
   a_abort: assert property (p_abort) else $error("Abort misbehaved.");

   c_read: cover property (@(posedge mclk) snap_go);
   c_write: cover property (@(posedge mclk) wr_go && cmd_q == IOXP_CMD_OUT_A);
   c_miss: cover property (@(posedge mclk) byte_end && is_addr && !addr_hit);
   c_irq: cover property (@(posedge mclk) set_b ##1 change_irq_n_oe);
endmodule
`default_nettype wire

// ===== ioxp_mst_model.sv
// Purpose: Behavioural two-wire bus master that drives the serial clock and data line.
// Assumes: The data line has a pull-up; the master only pulls it low or releases it.
// Notes:   Each clock phase of a bit lasts 8 mclk, longer than the shortest phase the slave accepts.
`timescale 1ns/1ps
`default_nettype none
module ioxp_mst_model (
   input  wire logic mclk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_low
);
   // Idle bus: clock high and data released to the pull-up.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Quarter of a bit time, counted on the falling edge so pins never move on the sampling edge.
   task hp();
      repeat (4) @(negedge mclk);
   endtask

   // Data falls while the clock is high; also serves as a repeated start.
   task start();
      sda_low = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      hp();
      sda_low = 1'b1;
      hp();
      hp();
      scl = 1'b0;
      hp();
   endtask

   // Data rises while the clock is high, leaving the bus free.
   task stop();
      sda_low = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      hp();
      sda_low = 1'b0;
      hp();
      hp();
   endtask

   // One bit per pulse; data changes only while the clock is low.
   task xfer_bit(input logic b, output logic r);
      sda_low = ~b;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      hp();
      scl = 1'b0;
      hp();
   endtask

   // MSB first, then a ninth pulse with the line released for the slave to pull low.
   task wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(d[i], r);
      end
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask

   // Receive a byte, then answer the ninth pulse; a nack ends the read.
   task rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, d[i]);
      end
      xfer_bit(~ack, r);
   endtask
endmodule
`default_nettype wire

// ===== ioxp_pkg.sv
// Purpose: Shared constants, states and carrier types for the I/O expander serial slave.
// Assumes: Port group A is the open-drain group, group B the push-pull group.
// Notes:   Port values travel in the upper nibble of every data byte.
`default_nettype none
package ioxp_pkg;
   // Fixed upper address bits of the slave address.
   localparam logic [4:0] IOXP_FIXED_ADDR = 5'h16;
   // Bit count that marks a complete byte.
   localparam logic [3:0] IOXP_BIT_LAST = 4'h8;
   // Command byte values selecting the internal registers.
   localparam logic [7:0] IOXP_CMD_IN_A   = 8'h00;
   localparam logic [7:0] IOXP_CMD_IN_B   = 8'h01;
   localparam logic [7:0] IOXP_CMD_OUT_A  = 8'h02;
   localparam logic [7:0] IOXP_CMD_OUT_B  = 8'h03;
   localparam logic [7:0] IOXP_CMD_DIR_A  = 8'h04;
   localparam logic [7:0] IOXP_CMD_DIR_B  = 8'h05;
   localparam logic [7:0] IOXP_CMD_MASK_A = 8'h06;
   localparam logic [7:0] IOXP_CMD_MASK_B = 8'h07;
   // Values after reset.
   localparam logic [3:0] IOXP_DIR_RESET  = 4'h0;
   localparam logic [3:0] IOXP_MASK_RESET = 4'h0;
   localparam logic [7:0] IOXP_CMD_RESET  = 8'h00;
   // Byte position within a transfer.
   localparam logic [1:0] IOXP_BYTE_ADDR = 2'h0;
   localparam logic [1:0] IOXP_BYTE_CMD  = 2'h1;
   localparam logic [1:0] IOXP_BYTE_DATA = 2'h2;

   typedef enum logic [2:0] {
      IOXP_ST_IDLE   = 3'b000,
      IOXP_ST_RX     = 3'b001,
      IOXP_ST_RX_ACK = 3'b010,
      IOXP_ST_TX     = 3'b011,
      IOXP_ST_TX_ACK = 3'b100,
      IOXP_ST_IGNORE = 3'b101
   } ioxp_state_t;

   // Software-visible settings of one port group.
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] dir;
      logic [3:0] mask;
   } ioxp_grp_t;
endpackage
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the I/O expander serial slave.
// Assumes: Address strap tied high, so the slave answers B4h for writes and B5h for reads.
// Notes:   Reset is held four cycles so the two-stage pin synchronisers have settled before it is released.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ioxp_pkg::*;
   logic       mclk = 1'b0;
   logic       reset_n = 1'b0;
   logic       abort_n = 1'b1;
   logic [3:0] ext_a = 4'hF;
   logic [3:0] ext_b = 4'hF;
   logic       sda_o, sda_oe, irq_o, irq_oe, a, r;
   logic [3:0] od_o, od_oe, pp_o, pp_oe;
   logic [7:0] d;
   wire        scl, m_low;
   int         fail_count = 0;
   int         n_tests = 0;

   // Wired levels: pull-up on data, open-drain group pulled low, push-pull group driven when output.
   wire       sda  = ~(sda_oe | m_low);
   wire [3:0] od_i = ext_a & ~od_oe;
   wire [3:0] pp_i = (pp_oe & pp_o) | (~pp_oe & ext_b);

   always #5 mclk = ~mclk;

   ioxp_i2c_slave i_dut (
      .mclk(mclk), .reset_n(reset_n), .bus_abort_n(abort_n), .pin_addr_bit(1'b1),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .open_drain_ports_i(od_i), .open_drain_ports_o(od_o), .open_drain_ports_oe(od_oe),
      .push_pull_ports_i(pp_i), .push_pull_ports_o(pp_o), .push_pull_ports_oe(pp_oe),
      .change_irq_n_o(irq_o), .change_irq_n_oe(irq_oe)
   );

   ioxp_mst_model i_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));

   task end_sim();
      $display("tests %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Write one data byte after the command byte; every byte must be acknowledged.
   task wr(input logic [7:0] cmd, input logic [7:0] dat);
      i_mst.start();
      i_mst.wbyte(8'hB4, a);
      chk(a, 1, "addr ack");
      i_mst.wbyte(cmd, a);
      chk(a, 1, "cmd ack");
      i_mst.wbyte(dat, a);
      chk(a, 1, "data ack");
      i_mst.stop();
   endtask

   // Command byte, repeated start, read address, one byte closed with a nack.
   task rd(input logic [7:0] cmd, input logic [7:0] exp);
      i_mst.start();
      i_mst.wbyte(8'hB4, a);
      i_mst.wbyte(cmd, a);
      i_mst.start();
      i_mst.wbyte(8'hB5, a);
      chk(a, 1, "read addr ack");
      i_mst.rbyte(1'b0, d);
      i_mst.stop();
      chk(d, exp, "read data");
   endtask

   task settle();
      repeat (10) @(negedge mclk);
   endtask

   // Hang guard: a run that overstays counts as a mismatch.
   initial begin
      repeat (100000) @(posedge mclk);
      fail_count++;
      end_sim();
   end

   // Main sequence.
   initial begin
      repeat (4) @(negedge mclk);
      reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      chk(pp_oe, 4'hF, "dir reset");
      chk(pp_o, 4'hF, "out reset");
      chk(od_oe, 4'h0, "od reset");
      chk(irq_oe, 0, "irq reset");
      chk({2'b00, sda_o, irq_o, od_o}, 8'h00, "open drain levels");
      $display("test reset done");

      // Two bytes in one write, each applied at once; low nibble ignored.
      i_mst.start();
      i_mst.wbyte(8'hB4, a);
      i_mst.wbyte(IOXP_CMD_OUT_B, a);
      i_mst.wbyte(8'hA0, a);
      chk(pp_o, 4'hA, "first out byte");
      i_mst.wbyte(8'h5F, a);
      chk(a, 1, "second ack");
      chk(pp_o, 4'h5, "second out byte");
      i_mst.stop();
      settle();
      chk(irq_oe, 0, "output write irq");
      rd(IOXP_CMD_OUT_B, 8'h50);
      $display("test multi write done");

      // Strap mismatch and a set low address bit get no acknowledge, and the data is dropped.
      for (int i = 0; i < 2; i++) begin
         i_mst.start();
         i_mst.wbyte(i == 0 ? 8'hB0 : 8'hB6, a);
         chk(a, 0, "foreign addr nack");
         i_mst.wbyte(IOXP_CMD_OUT_A, a);
         i_mst.wbyte(8'h00, a);
         i_mst.stop();
         chk(od_oe, 4'h0, "foreign write ignored");
      end
      $display("test address done");

      // Direction: clear bit drives, set bit releases.
      wr(IOXP_CMD_OUT_A, 8'h00);
      chk(od_oe, 4'hF, "od outputs low");
      wr(IOXP_CMD_DIR_A, 8'hF0);
      wr(IOXP_CMD_DIR_B, 8'hF0);
      chk(od_oe, 4'h0, "od inputs");
      chk(pp_oe, 4'h0, "pp inputs");
      rd(IOXP_CMD_DIR_A, 8'hF0);
      wr(IOXP_CMD_IN_A, 8'h00);
      rd(IOXP_CMD_IN_A, 8'hF0);
      $display("test direction done");

      // Change flag, group-local clearing and re-arming.
      ext_a = 4'h6;
      settle();
      chk(irq_oe, 1, "change flags");
      rd(IOXP_CMD_IN_B, 8'hF0);
      chk(irq_oe, 1, "other group keeps flag");
      rd(IOXP_CMD_IN_A, 8'h60);
      chk(irq_oe, 0, "read clears");
      ext_a = 4'h7;
      settle();
      chk(irq_oe, 1, "new reference flags");
      rd(IOXP_CMD_OUT_A, 8'h00);
      chk(irq_oe, 0, "output reg read clears");
      wr(IOXP_CMD_MASK_A, 8'hF0);
      ext_a = 4'h3;
      settle();
      chk(irq_oe, 0, "masked change");
      wr(IOXP_CMD_MASK_A, 8'h00);
      settle();
      chk(irq_oe, 1, "unmasked change");
      $display("test interrupt done");

      // Abort during the address acknowledge; the pending flag survives.
      i_mst.start();
      for (int i = 7; i >= 0; i--) begin
         i_mst.xfer_bit(8'hB4 >> i, r);
      end
      repeat (6) @(negedge mclk);
      chk(sda_oe, 1, "ack driven");
      abort_n = 1'b0;
      repeat (6) @(negedge mclk);
      chk(sda_oe, 0, "abort releases");
      chk(irq_oe, 1, "abort keeps irq");
      abort_n = 1'b1;
      repeat (4) @(negedge mclk);
      i_mst.stop();
      rd(IOXP_CMD_IN_A, 8'h30);
      chk(irq_oe, 0, "read after abort");
      $display("test abort done");
      end_sim();
   end
endmodule
`default_nettype wire
